/* File: qpd_decoder.sv */
// Serial command decoder for a quad digital potentiometer
`timescale 1ns/1ps
module qpd_decoder (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic si,
    input wire logic [1:0] chip_address_bits,
    output logic so_out,
    output logic so_oe,
    output logic [23:0] wiper_positions,
    output logic write_in_progress_flag
);
    // ==========================================
    // Pin synchronisers
    // Equal depth on all pins keeps each data bit aligned with its clock edge
    logic [1:0] cs_sync_ff;
    logic [1:0] sck_sync_ff;
    logic [1:0] si_sync_ff;
    logic cs_prev_ff;
    logic sck_prev_ff;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cs_sync_ff <= 2'h3;
            sck_sync_ff <= 2'h0;
            si_sync_ff <= 2'h0;
            cs_prev_ff <= 1'b1;
            sck_prev_ff <= 1'b0;
        end else begin
            cs_sync_ff <= {cs_sync_ff[0], cs_n};
            sck_sync_ff <= {sck_sync_ff[0], sck};
            si_sync_ff <= {si_sync_ff[0], si};
            cs_prev_ff <= cs_sync_ff[1];
            sck_prev_ff <= sck_sync_ff[1];
        end
    end
    wire cs_low = ~cs_sync_ff[1];
    wire frame_start = cs_prev_ff & ~cs_sync_ff[1];
    wire frame_end = ~cs_prev_ff & cs_sync_ff[1];
    wire sck_rise = cs_low & ~sck_prev_ff & sck_sync_ff[1];
    wire sck_fall = cs_low & sck_prev_ff & ~sck_sync_ff[1];
    wire si_bit = si_sync_ff[1];

    // ==========================================
    // Frame shifter
    typedef enum logic [3:0] {
        st_idle = 4'h1,
        st_shift = 4'h2,
        st_ignore = 4'h4,
        st_step = 4'h8
    } qpd_state_type;
    qpd_state_type state_ff, nxt_state;
    logic [5:0] bit_cnt_ff;
    logic [7:0] addr_byte_ff;
    qpd_pkg::qpd_cmd_type cmd_ff;
    logic [7:0] data_ff;
    logic [7:0] tx_ff;
    logic so_oe_ff;
    logic [5:0] wiper_ff [4];
    logic [5:0] slot_ff [16];
    logic [31:0] nv_cnt_ff;
    logic [5:0] nv_data_ff;
    logic [3:0] nv_idx_ff;

    function automatic logic [3:0] slot_index(input logic [1:0] pot, input logic [1:0] slot);
        slot_index = {pot, slot};
    endfunction : slot_index


    // ==========================================
    // Command decode
    wire [7:0] shifted = {addr_byte_ff[6:0], si_bit};
    wire [7:0] own_addr_byte = {qpd_pkg::dev_type_id, 2'b00, chip_address_bits};
    wire in_shift = state_ff == st_shift;
    wire end_shift = frame_end & in_shift;
    wire byte1_done = sck_rise & (bit_cnt_ff == qpd_pkg::bit_byte1 - 6'h01);
    wire byte2_done = sck_rise & (bit_cnt_ff == qpd_pkg::bit_byte2 - 6'h01);
    wire [7:0] cmd_next = {cmd_ff[6:0], si_bit};
    wire [3:0] sel = slot_index(cmd_ff.pot, cmd_ff.slot);
    wire [5:0] cur_wiper = wiper_ff[cmd_ff.pot];
    wire nv_busy = nv_cnt_ff != 32'h0;
    // Frame length decides commit; short frames fall through untouched
    wire have_two = bit_cnt_ff >= qpd_pkg::bit_byte2;
    wire have_three = bit_cnt_ff >= qpd_pkg::bit_byte3;
    wire do_wr_wiper = end_shift & have_three & cmd_ff.op == qpd_pkg::op_wr_wiper;
    wire do_wr_slot = end_shift & have_three & cmd_ff.op == qpd_pkg::op_wr_slot & ~nv_busy;
    wire do_s2w = end_shift & have_two & cmd_ff.op == qpd_pkg::op_slot_to_wiper;
    wire do_w2s = end_shift & have_two & cmd_ff.op == qpd_pkg::op_wiper_to_slot & ~nv_busy;
    wire do_glob = end_shift & have_two & cmd_ff.op == qpd_pkg::op_global_load;
    wire do_step = state_ff == st_step & sck_rise;

    // A mismatched first byte parks the frame until chip select rises
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            st_idle: if (frame_start) nxt_state = st_shift;
            st_shift: begin
                if (frame_end) nxt_state = st_idle;
                else if (byte1_done & shifted != own_addr_byte)
                    nxt_state = st_ignore;
                else if (byte2_done & cmd_next[7:4] == qpd_pkg::op_step) nxt_state = st_step;
            end
            st_ignore: if (frame_end) nxt_state = st_idle;
            st_step: if (frame_end) nxt_state = st_idle;
            default: nxt_state = st_idle;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_ff <= st_idle;
            bit_cnt_ff <= 6'h0;
            addr_byte_ff <= 8'h0;
            cmd_ff <= '0;
            data_ff <= 8'h0;
        end else begin
            state_ff <= nxt_state;
            // Count saturates so an overlong frame cannot wrap into a short one
            if (frame_start) bit_cnt_ff <= 6'h0;
            else if (sck_rise & in_shift & bit_cnt_ff != qpd_pkg::wiper_max) bit_cnt_ff <= bit_cnt_ff + 6'h01;
            if (sck_rise & in_shift) begin
                if (bit_cnt_ff < qpd_pkg::bit_byte1) addr_byte_ff <= shifted;
                else if (bit_cnt_ff < qpd_pkg::bit_byte2) cmd_ff <= cmd_next;
                else if (bit_cnt_ff < qpd_pkg::bit_byte3) data_ff <= {data_ff[6:0], si_bit};
            end
        end
    end

    // ==========================================
    // Serial output; loaded after byte two, shifted on falling clock
    always_ff @(posedge core_clk) begin
        if (rst) begin
            tx_ff <= 8'h0;
            so_oe_ff <= 1'b0;
        end else if (frame_end | frame_start) begin
            so_oe_ff <= 1'b0;
        end else if (byte2_done & in_shift) begin
            case (cmd_next[7:4])
                qpd_pkg::op_rd_wiper: begin
                    tx_ff <= {2'b00, wiper_ff[cmd_next[1:0]]};
                    so_oe_ff <= 1'b1;
                end
                qpd_pkg::op_rd_slot: begin
                    tx_ff <= {2'b00, slot_ff[slot_index(cmd_next[1:0], cmd_next[3:2])]};
                    so_oe_ff <= 1'b1;
                end
                qpd_pkg::op_status: begin
                    tx_ff <= {7'h0, nv_busy};
                    so_oe_ff <= 1'b1;
                end
                default: so_oe_ff <= 1'b0;
            endcase
        end else if (sck_fall & so_oe_ff & bit_cnt_ff > qpd_pkg::bit_byte2) begin
            tx_ff <= {tx_ff[6:0], 1'b0};
        end
    end
    qpd_pkg::qpd_so_type so_pins;
    assign so_pins = {tx_ff[7], so_oe_ff};
    assign so_out = so_pins.so_out;
    assign so_oe = so_pins.so_oe;

    // ==========================================
    // Wipers, saved slots and write timer
    // Slot writes during a busy cycle are dropped, as the array cannot take them
    always_ff @(posedge core_clk) begin
        if (rst) begin
            nv_cnt_ff <= 32'h0;
            nv_data_ff <= 6'h0;
            nv_idx_ff <= 4'h0;
        end else if (do_wr_slot | do_w2s) begin
            nv_cnt_ff <= 32'(qpd_pkg::nv_write_cycles);
            nv_data_ff <= do_wr_slot ? data_ff[5:0] : cur_wiper;
            nv_idx_ff <= sel;
        end else if (nv_busy) begin
            nv_cnt_ff <= nv_cnt_ff - 32'h1;
        end
    end
    assign write_in_progress_flag = nv_busy;

    // Slot takes its new value only as the write timer expires
    genvar g;
    generate
        for (g = 0; g < 16; g++) begin : g_slot
            always_ff @(posedge core_clk) begin
                if (rst) slot_ff[g] <= qpd_pkg::wiper_reset_val;
                else if (nv_cnt_ff == 32'h1 & nv_idx_ff == 4'(g)) slot_ff[g] <= nv_data_ff;
            end
        end
        // Step saturates at both ends rather than wrapping
        for (g = 0; g < 4; g++) begin : g_wiper
            wire mine = cmd_ff.pot == 2'(g);
            always_ff @(posedge core_clk) begin
                if (rst) wiper_ff[g] <= qpd_pkg::wiper_reset_val;
                else if (do_wr_wiper & mine) wiper_ff[g] <= data_ff[5:0];
                else if (do_s2w & mine) wiper_ff[g] <= slot_ff[sel];
                else if (do_glob) wiper_ff[g] <= slot_ff[slot_index(2'(g), cmd_ff.slot)];
                else if (do_step & mine & si_bit & wiper_ff[g] != qpd_pkg::wiper_max)
                    wiper_ff[g] <= wiper_ff[g] + 6'h01;
                else if (do_step & mine & ~si_bit & wiper_ff[g] != 6'h00)
                    wiper_ff[g] <= wiper_ff[g] - 6'h01;
            end
            assign wiper_positions[g*6 +: 6] = wiper_ff[g];
        end
    endgenerate
endmodule : qpd_decoder

/* File: qpd_pkg.sv */
// Package for the quad pot serial command decoder
package qpd_pkg;
    localparam logic [3:0] dev_type_id = 4'h5;
    localparam logic [7:0] op_wiper_read = 8'h09;
    localparam logic [3:0] op_rd_wiper = 4'h9;
    localparam logic [3:0] op_wr_wiper = 4'ha;
    localparam logic [3:0] op_rd_slot = 4'hb;
    localparam logic [3:0] op_wr_slot = 4'hc;
    localparam logic [3:0] op_slot_to_wiper = 4'hd;
    localparam logic [3:0] op_wiper_to_slot = 4'he;
    localparam logic [3:0] op_step = 4'h2;
    localparam logic [3:0] op_global_load = 4'h1;
    localparam logic [3:0] op_status = 4'h5;
    localparam logic [5:0] wiper_max = 6'h3f;
    localparam logic [5:0] wiper_reset_val = 6'h00;
    localparam logic [5:0] bit_byte1 = 6'h08;
    localparam logic [5:0] bit_byte2 = 6'h10;
    localparam logic [5:0] bit_byte3 = 6'h18;
    localparam int core_clk_mhz = 20;
    localparam int nv_write_time_us = 10;
    localparam int nv_write_cycles = nv_write_time_us * core_clk_mhz;

    typedef struct packed {
        logic [3:0] op;
        logic [1:0] slot;
        logic [1:0] pot;
    } qpd_cmd_type;

    typedef struct packed {
        logic so_out;
        logic so_oe;
    } qpd_so_type;
endpackage : qpd_pkg

/* File: qpd_decoder_checker.sv */
// Checker for serial output, write flag and wiper timing
`timescale 1ns/1ps
module qpd_decoder_checker (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic si,
    input wire logic [1:0] chip_address_bits,
    input wire logic so_out,
    input wire logic so_oe,
    input wire logic [23:0] wiper_positions,
    input wire logic write_in_progress_flag
);
    localparam int wr_cycles = qpd_pkg::nv_write_cycles;
    logic [9:0] busy_cnt_ff;
    logic [9:0] nxt_busy_cnt;
    // Ten bits are plenty for a 200-cycle write
    assign nxt_busy_cnt = write_in_progress_flag ? busy_cnt_ff + 10'h001 : 10'h000;
    always_ff @(posedge core_clk) begin
        busy_cnt_ff <= rst ? 10'h000 : nxt_busy_cnt;
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    // ==========================================
    // Assertions
    a_oe_in_frame: assert property ($rose(so_oe) |-> !cs_n)
        else $error("output enabled outside a frame");
    a_oe_after_clock: assert property ($rose(so_oe) |-> sck)
        else $error("output enabled away from a rising clock");
    a_oe_release: assert property ($rose(cs_n) |-> ##[1:6] !so_oe)
        else $error("output held after frame");
    a_oe_idle_off: assert property (cs_n [*8] |-> !so_oe)
        else $error("output enabled while idle");
    a_oe_holds: assert property ($rose(so_oe) ##1 !cs_n [*6] |-> so_oe)
        else $error("output dropped early");
    a_lead_zeros: assert property ($rose(so_oe) |-> !so_out [*8])
        else $error("leading bits not zero");
    a_flag_span: assert property ($fell(write_in_progress_flag) |-> busy_cnt_ff >= wr_cycles)
        else $error("write flag too short");
    a_flag_at_end: assert property ($rose(write_in_progress_flag) |-> cs_n)
        else $error("write began in frame");
    a_wiper_idle: assert property (cs_n [*8] |=> $stable(wiper_positions))
        else $error("wiper moved while idle");
endmodule : qpd_decoder_checker
bind qpd_decoder qpd_decoder_checker chk_i (.core_clk(core_clk), .rst(rst), .cs_n(cs_n), .sck(sck), .si(si),
    .chip_address_bits(chip_address_bits), .so_out(so_out), .so_oe(so_oe), .wiper_positions(wiper_positions),
    .write_in_progress_flag(write_in_progress_flag));

/* File: qpd_host_model.sv */
// Host controller model driving the serial frame pins
`timescale 1ns/1ps
module qpd_host_model (
    input wire logic core_clk,
    input wire logic so_out,
    input wire logic so_oe,
    output logic cs_n,
    output logic sck,
    output logic si
);
    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        si = 1'b0;
    end
    // ==========================================
    // Frame: 400 ns per clock phase, clock still between frames
    task automatic frame(input logic [23:0] bits, input int n, output logic [7:0] rd, output logic oe);
        rd = 8'h00;
        oe = 1'b0;
        cs_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            si = bits[23 - i];
            repeat (8) @(negedge core_clk);
            sck = 1'b1;
            // Undriven output reads as the inverse of the last bit
            rd = {rd[6:0], so_oe ? so_out : ~rd[0]};
            oe = oe | so_oe;
            repeat (8) @(negedge core_clk);
            sck = 1'b0;
        end
        repeat (8) @(negedge core_clk);
        cs_n = 1'b1;
        si = ~si;
        repeat (12) @(negedge core_clk);
    endtask : frame
endmodule : qpd_host_model

/* File: qpd_decoder_tb.sv */
// Self-checking bench for the quad pot command decoder
`timescale 1ns/1ps
module qpd_decoder_tb;
    logic core_clk, rst, cs_n, sck, si, so_out, so_oe, flag, busy;
    logic [1:0] addr;
    logic [23:0] wipers;
    logic [15:0] lf = 16'hdcc7;
    logic [5:0] w[4];
    logic [5:0] sl[16];
    int failures = 0;
    int check_count = 0;
    // End of the running nonvolatile write, in ns; one link bit is 800 ns
    longint nv_end = 0;
    localparam longint sck_period_ns = 800;
    qpd_decoder dut (.core_clk(core_clk), .rst(rst), .cs_n(cs_n), .sck(sck), .si(si), .chip_address_bits(addr),
        .so_out(so_out), .so_oe(so_oe), .wiper_positions(wipers), .write_in_progress_flag(flag));
    qpd_host_model host (.core_clk(core_clk), .so_out(so_out), .so_oe(so_oe), .cs_n(cs_n), .sck(sck), .si(si));
    function automatic logic [15:0] rnd(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : rnd
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : give_verdict
    // ==========================================
    // Frame plus reference model update
    task automatic op(input logic [3:0] o, input logic [1:0] s, input logic [1:0] p, input logic [7:0] d,
        input int n, input logic [1:0] a);
        logic [7:0] rd, e;
        logic oe, ok, rdop, nv_free;
        longint t_start, t_end;
        t_start = $time;
        host.frame({qpd_pkg::dev_type_id, 2'b00, a, o, s, p, d}, n, rd, oe);
        t_end = $time;
        repeat (12) @(negedge core_clk);
        ok = a == addr && n >= (o inside {4'ha, 4'hc} ? 24 : 16);
        rdop = ok && o inside {4'h9, 4'hb, 4'h5};
        // A slot write that meets a running write is dropped
        nv_free = t_end >= nv_end;
        e = 8'h00;
        if (ok) begin
            case (o)
                4'ha: w[p] = d[5:0];
                4'hc: if (nv_free) sl[{p, s}] = d[5:0];
                4'hd: w[p] = sl[{p, s}];
                4'he: if (nv_free) sl[{p, s}] = w[p];
                4'h1: for (int k = 0; k < 4; k++) w[k] = sl[{k[1:0], s}];
                4'h2: for (int i = 7; i >= 0; i--) begin
                    if (d[i] && w[p] != 6'h3f) w[p]++;
                    else if (!d[i] && w[p] != 6'h00) w[p]--;
                end
                4'h9: e = {2'b00, w[p]};
                4'hb: e = {2'b00, sl[{p, s}]};
                // Status is taken once the opcode byte is in
                4'h5: e = {7'h00, t_start + 16 * sck_period_ns < nv_end};
                default: ;
            endcase
            if (nv_free && o inside {4'hc, 4'he}) nv_end = t_end + qpd_pkg::nv_write_cycles * 50;
        end
        busy = $time < nv_end;
        if (rdop) chk({16'h0000, rd}, {16'h0000, e});
        chk({23'h000000, oe}, {23'h000000, rdop});
        chk(wipers, {w[3], w[2], w[1], w[0]});
        chk({23'h000000, flag}, {23'h000000, busy});
    endtask : op
    task automatic idle;
        for (int i = 0; i < 400 && flag !== 1'b0; i++) @(negedge core_clk);
        busy = 1'b0;
        chk({23'h000000, flag}, 24'h000000);
    endtask : idle
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    initial begin
        repeat (60000) @(posedge core_clk);
        failures++;
        give_verdict();
    end
    initial begin
        rst = 1'b1;
        addr = lf[1:0];
        busy = 1'b0;
        foreach (w[i]) w[i] = 6'h00;
        foreach (sl[i]) sl[i] = 6'h00;
        repeat (6) @(negedge core_clk);
        rst = 1'b0;
        repeat (4) @(negedge core_clk);
        for (int p = 0; p < 4; p++) begin
            lf = rnd(lf);
            op(4'ha, 2'b00, p[1:0], {2'b00, lf[5:0]}, 24, addr);
            op(4'h9, 2'b00, p[1:0], 8'h00, 24, addr);
        end
        $display("test wiper access done");
        op(4'ha, 2'b00, 2'b01, 8'h3f, 20, addr);
        op(4'ha, 2'b00, 2'b10, 8'h15, 24, addr ^ 2'b01);
        op(4'h9, 2'b00, 2'b10, 8'h00, 24, addr ^ 2'b10);
        op(4'ha, 2'b00, 2'b00, 8'h3e, 24, addr);
        op(4'h2, 2'b11, 2'b00, 8'hff, 24, addr);
        $display("test refusals and saturation done");
        for (int s = 0; s < 4; s++) begin
            lf = rnd(lf);
            op(4'hc, s[1:0], lf[7:6], {2'b00, lf[5:0]}, 24, addr);
            op(4'h5, 2'b00, 2'b01, 8'h00, 24, addr);
            idle();
            op(4'hb, s[1:0], lf[7:6], 8'h00, 24, addr);
            op(4'he, s[1:0], 2'b11, 8'h00, 16, addr);
            idle();
            op(4'h2, s[1:0], s[1:0], lf[15:8], 24, addr);
            op(4'h1, s[1:0], 2'b00, 8'h00, 16, addr);
            op(4'hd, s[1:0], lf[7:6], 8'h00, 16, addr);
        end
        $display("test slots and transfers done");
        give_verdict();
    end
endmodule : qpd_decoder_tb
